// *** core/fab_pkg.sv ***
// fab_pkg: shared constants and carrier types for the flash bus host controller
// assumes a 20 MHz system clock; all pin timings are derived from it here
package fab_pkg;
  localparam int unsigned CLK_NS = 50;
  localparam int unsigned ADDR_W = 21;
  localparam int unsigned DATA_W = 16;
  // times in ns as printed
  localparam int unsigned READ_CYCLE_NS = 90;
  localparam int unsigned OE_ACCESS_NS = 40;
  localparam int unsigned POLL_OE_HOLD_NS = 10;
  localparam int unsigned POLL_OE_HIGH_NS = 20;
  localparam int unsigned RESET_PULSE_MIN_NS = 500;
  localparam int unsigned RESET_RELEASE_NS = 50;
  localparam int unsigned WORD_ACTIVE_NS = 90;
  localparam int unsigned WRITE_PULSE_NS = 35;
  localparam int unsigned WRITE_HIGH_NS = 30;
  localparam int unsigned BUSY_DELAY_NS = 90;
  // least times round up, never below one cycle
  function automatic int unsigned cyc_min(input int unsigned ns);
    int unsigned c;
    c = (ns + CLK_NS - 1) / CLK_NS;
    return (c < 1) ? 1 : c;
  endfunction
  localparam int unsigned READ_CYCLE_CYC = cyc_min(READ_CYCLE_NS);
  localparam int unsigned OE_ACCESS_CYC = cyc_min(OE_ACCESS_NS);
  localparam int unsigned POLL_OE_HOLD_CYC = cyc_min(POLL_OE_HOLD_NS);
  localparam int unsigned POLL_OE_HIGH_CYC = cyc_min(POLL_OE_HIGH_NS);
  localparam int unsigned RESET_PULSE_CYC = cyc_min(RESET_PULSE_MIN_NS);
  localparam int unsigned RESET_RELEASE_CYC = cyc_min(RESET_RELEASE_NS);
  localparam int unsigned WORD_ACTIVE_CYC = cyc_min(WORD_ACTIVE_NS);
  localparam int unsigned WRITE_PULSE_CYC = cyc_min(WRITE_PULSE_NS);
  localparam int unsigned WRITE_HIGH_CYC = cyc_min(WRITE_HIGH_NS);
  localparam int unsigned BUSY_DELAY_CYC = cyc_min(BUSY_DELAY_NS);
  localparam int unsigned CNT_W = 8;
  typedef enum logic [1:0] {
    FAB_OP_READ,
    FAB_OP_WRITE,
    FAB_OP_POLL,
    FAB_OP_RESET
  } fab_op_t;
  typedef struct packed {
    fab_op_t op;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } fab_req_t;
  typedef struct packed {
    logic sel_n;
    logic oe_n;
    logic we_n;
    logic reset_n;
    logic width_select;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] dq_o;
    logic dq_oe;
  } fab_pins_t;
endpackage

// *** core/fab_host.sv ***
// fab_host: host-side sequencer driving the asynchronous flash bus pins
// assumes dq and ready_busy_n come from the flash pins and are unsynchronised
module fab_host #(
  parameter int unsigned RESET_HOLD_CYC = fab_pkg::RESET_PULSE_CYC
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic req_valid_i,
  input wire fab_pkg::fab_req_t req_i,
  input wire logic word_mode_i,
  output logic req_ready_o,
  output logic rsp_valid_o,
  output logic [fab_pkg::DATA_W-1:0] rsp_data_o,
  output logic busy_o,
  output fab_pkg::fab_pins_t pins_o,
  input wire logic [fab_pkg::DATA_W-1:0] dq_i,
  input wire logic ready_busy_n_i
);
  typedef enum logic [3:0] {
    FAB_IDLE, FAB_RD, FAB_RD_GAP, FAB_WR_LOW, FAB_WR_HIGH, FAB_WAIT_BUSY,
    FAB_RST_LOW, FAB_RST_HIGH, FAB_WIDTH
  } fab_state_t;
  typedef struct packed {
    fab_state_t st;
    logic [fab_pkg::CNT_W-1:0] cnt;
    logic poll;
    fab_pkg::fab_pins_t pins;
    logic req_ready;
    logic rsp_valid;
    logic [fab_pkg::DATA_W-1:0] rsp_data;
    logic busy;
    logic [fab_pkg::DATA_W-1:0] dq_s1;
    logic [fab_pkg::DATA_W-1:0] dq_s2;
    logic rb_s1;
    logic rb_s2;
    logic [fab_pkg::CNT_W-1:0] we_gap;
  } fab_host_state_t;
  fab_host_state_t s_reg;
  fab_host_state_t s_next;

  function automatic logic [fab_pkg::CNT_W-1:0] cw(input int unsigned v);
    return fab_pkg::CNT_W'(v);
  endfunction

  // Behaviour
  // - each read cycle from address change to next lasts at least 90 ns
  // - wait 10 ns after write strobe rises before status poll read enable
  // - keep output enable high 20 ns between successive status polls
  // - hold reset low 500 ns, then wait 50 ns before first read
  // - allow 90 ns after selecting word mode before expecting valid data
  // - raise output enable before write strobe falls, 0 ns apart
  // - write address may be set 0 ns before the latching strobe edge
  always_comb
  begin
    s_next = s_reg;
    s_next.rsp_valid = 1'b0;
    s_next.dq_s1 = dq_i;
    s_next.dq_s2 = s_reg.dq_s1;
    s_next.rb_s1 = ready_busy_n_i;
    s_next.rb_s2 = s_reg.rb_s1;
    if (s_reg.we_gap != '0)
    begin
      s_next.we_gap = s_reg.we_gap - cw(1);
    end
    if (s_reg.cnt != '0)
    begin
      s_next.cnt = s_reg.cnt - cw(1);
    end
    unique case (s_reg.st)
      FAB_IDLE:
      begin
        s_next.req_ready = 1'b0;
        if (word_mode_i != s_reg.pins.width_select)
        begin
          // width change only between cycles; word mode needs settle time
          s_next.pins.width_select = word_mode_i;
          s_next.cnt = cw(fab_pkg::WORD_ACTIVE_CYC);
          s_next.st = FAB_WIDTH;
        end
        else if (s_reg.req_ready && req_valid_i)
        begin
          s_next.pins.addr = req_i.addr;
          s_next.poll = (req_i.op == fab_pkg::FAB_OP_POLL);
          unique case (req_i.op)
            fab_pkg::FAB_OP_WRITE:
            begin
              s_next.pins.oe_n = 1'b1;
              s_next.pins.sel_n = 1'b0;
              s_next.pins.we_n = 1'b0;
              s_next.pins.dq_o = req_i.wdata;
              s_next.pins.dq_oe = 1'b1;
              s_next.cnt = cw(fab_pkg::WRITE_PULSE_CYC);
              s_next.st = FAB_WR_LOW;
            end
            fab_pkg::FAB_OP_RESET:
            begin
              s_next.pins.reset_n = 1'b0;
              s_next.cnt = cw(RESET_HOLD_CYC);
              s_next.st = FAB_RST_LOW;
            end
            default:
            begin
              s_next.pins.sel_n = 1'b0;
              s_next.pins.oe_n = 1'b0;
              // read cycle spans the read cycle time plus two cycles for the dq synchroniser
              s_next.cnt = cw(fab_pkg::READ_CYCLE_CYC + 2);
              s_next.st = FAB_RD;
            end
          endcase
        end
        else if (s_reg.we_gap == '0 && !(s_reg.busy && s_reg.rb_s2 == 1'b0))
        begin
          s_next.req_ready = 1'b1;
        end
      end
      FAB_RD:
      begin
        if (s_reg.cnt == cw(1))
        begin
          // sample before releasing strobes since hold is only 0 ns
          s_next.rsp_data = s_reg.pins.width_select ? s_reg.dq_s2 : {8'h00, s_reg.dq_s2[7:0]};
          s_next.rsp_valid = 1'b1;
          s_next.pins.oe_n = 1'b1;
          s_next.pins.sel_n = 1'b1;
          s_next.cnt = cw(s_reg.poll ? fab_pkg::POLL_OE_HIGH_CYC : 1);
          s_next.st = FAB_RD_GAP;
        end
      end
      FAB_RD_GAP:
      begin
        if (s_reg.cnt == cw(1))
        begin
          s_next.st = FAB_IDLE;
        end
      end
      FAB_WR_LOW:
      begin
        if (s_reg.cnt == cw(1))
        begin
          s_next.pins.we_n = 1'b1;
          s_next.pins.sel_n = 1'b1;
          s_next.cnt = cw(fab_pkg::WRITE_HIGH_CYC);
          s_next.we_gap = cw(fab_pkg::POLL_OE_HOLD_CYC);
          s_next.st = FAB_WR_HIGH;
        end
      end
      FAB_WR_HIGH:
      begin
        if (s_reg.cnt == cw(1))
        begin
          s_next.pins.dq_oe = 1'b0;
          s_next.cnt = cw(fab_pkg::BUSY_DELAY_CYC + 2);
          s_next.st = FAB_WAIT_BUSY;
        end
      end
      FAB_WAIT_BUSY:
      begin
        // allow the busy flag time to appear before trusting ready
        if (s_reg.rb_s2 == 1'b0)
        begin
          s_next.busy = 1'b1;
        end
        if (s_reg.cnt == cw(1))
        begin
          s_next.st = FAB_IDLE;
        end
      end
      FAB_RST_LOW:
      begin
        if (s_reg.cnt == cw(1))
        begin
          s_next.pins.reset_n = 1'b1;
          s_next.cnt = cw(fab_pkg::RESET_RELEASE_CYC);
          s_next.st = FAB_RST_HIGH;
        end
      end
      FAB_RST_HIGH, FAB_WIDTH:
      begin
        if (s_reg.cnt == cw(1))
        begin
          s_next.st = FAB_IDLE;
        end
      end
    endcase
    if (s_reg.busy && s_reg.rb_s2 == 1'b1 && s_reg.st != FAB_WAIT_BUSY)
    begin
      s_next.busy = 1'b0;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
    begin
      s_reg <= '0;
      s_reg.st <= FAB_IDLE;
      s_reg.pins.sel_n <= 1'b1;
      s_reg.pins.oe_n <= 1'b1;
      s_reg.pins.we_n <= 1'b1;
      s_reg.pins.reset_n <= 1'b1;
      s_reg.pins.width_select <= 1'b1;
      s_reg.rb_s1 <= 1'b1;
      s_reg.rb_s2 <= 1'b1;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  assign req_ready_o = s_reg.req_ready;
  assign rsp_valid_o = s_reg.rsp_valid;
  assign rsp_data_o = s_reg.rsp_data;
  assign busy_o = s_reg.busy;
  assign pins_o = s_reg.pins;

  property p_rd_len;
    @(posedge clk_i) disable iff (!rst_b_i)
      $fell(pins_o.oe_n) |-> pins_o.oe_n == 1'b0 [*2] ##1 !pins_o.oe_n;
  endproperty
  a_rd_len: assert property (p_rd_len) else $error("read strobe too short");
  property p_rst_len;
    @(posedge clk_i) disable iff (!rst_b_i)
      $fell(pins_o.reset_n) |-> !pins_o.reset_n [*8] ##1 !pins_o.reset_n ##1 !pins_o.reset_n;
  endproperty
  a_rst_len: assert property (p_rst_len) else $error("reset pulse too short");
  property p_rst_to_read;
    @(posedge clk_i) disable iff (!rst_b_i)
      $rose(pins_o.reset_n) |-> pins_o.oe_n [*2];
  endproperty
  a_rst_to_read: assert property (p_rst_to_read) else $error("read too soon after reset");
  property p_we_oe;
    @(posedge clk_i) disable iff (!rst_b_i)
      !pins_o.we_n |-> pins_o.oe_n;
  endproperty
  a_we_oe: assert property (p_we_oe) else $error("write strobe low with output enable low");
  property p_poll_gap;
    @(posedge clk_i) disable iff (!rst_b_i)
      $rose(pins_o.oe_n) |=> pins_o.oe_n;
  endproperty
  a_poll_gap: assert property (p_poll_gap) else $error("output enable high gap too short");
  property p_we_to_poll;
    @(posedge clk_i) disable iff (!rst_b_i)
      $rose(pins_o.we_n) |-> pins_o.oe_n [*2];
  endproperty
  a_we_to_poll: assert property (p_we_to_poll) else $error("read too soon after write");
  property p_word_settle;
    @(posedge clk_i) disable iff (!rst_b_i)
      $rose(pins_o.width_select) |-> !rsp_valid_o [*2];
  endproperty
  a_word_settle: assert property (p_word_settle) else $error("response too soon after word mode");
  property p_wr_pulse;
    @(posedge clk_i) disable iff (!rst_b_i)
      $fell(pins_o.we_n) |-> !pins_o.we_n ##1 pins_o.we_n;
  endproperty
  a_wr_pulse: assert property (p_wr_pulse) else $error("write pulse length wrong");
endmodule

// *** test/fab_flash_model.sv ***
// fab_flash_model: behavioural flash die answering the host pins
// assumes pins come from fab_host; drives data and ready/busy back
module fab_flash_model #(
  parameter int unsigned BUSY_CYC = 6
) (
  input wire logic clk_i,
  input wire fab_pkg::fab_pins_t pins_i,
  output logic [15:0] dq_o,
  output logic ready_busy_n_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] last_reg;
  logic [7:0] busy_reg = 8'h00;
  logic we_reg;
  logic drive;
  logic standby;
  int unsigned rst_low;
  // released lines show the inverse of the last value, never a stale copy
  assign drive = !pins_i.sel_n && !pins_i.oe_n && pins_i.reset_n && !standby;
  always_comb
  begin
    dq_o = ~last_reg;
    if (drive)
    begin
      dq_o[7:0] = pins_i.addr[7:0];
      dq_o[15:8] = pins_i.width_select ? (pins_i.addr[7:0] ^ 8'ha5) : ~last_reg[15:8];
    end
  end
  assign ready_busy_n_o = (busy_reg == 8'h00);
  assign standby = (rst_low >= 400);
  always_ff @(posedge clk_i)
  begin
    last_reg <= dq_o;
    we_reg <= pins_i.we_n;
    rst_low <= pins_i.reset_n ? 0 : rst_low + 1;
    if (!pins_i.reset_n)
      busy_reg <= 8'h00;
    else if (we_reg && !pins_i.we_n && !pins_i.sel_n)
      busy_reg <= 8'(BUSY_CYC);
    else if (busy_reg != 8'h00)
      busy_reg <= busy_reg - 8'h01;
  end
endmodule

// *** test/fab_host_bench.sv ***
// fab_host_bench: self-checking bench for the flash bus host
// assumes fab_flash_model on the far side and a 20 MHz clock
module fab_host_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 0;
  logic rst_b_i = 0;
  logic req_valid_i = 0;
  logic word_mode_i = 1;
  fab_pkg::fab_req_t req_i = '0;
  logic req_ready_o, rsp_valid_o, busy_o, ready_busy_n_i;
  logic [15:0] rsp_data_o, dq_i;
  fab_pkg::fab_pins_t pins_o;
  int err_count = 0;
  int comparisons = 0;
  int cycles = 0;
  initial forever #25 clk_i = ~clk_i;
  fab_host #(.RESET_HOLD_CYC(10)) dut_u (.clk_i(clk_i), .rst_b_i(rst_b_i), .req_valid_i(req_valid_i),
    .req_i(req_i), .word_mode_i(word_mode_i), .req_ready_o(req_ready_o), .rsp_valid_o(rsp_valid_o),
    .rsp_data_o(rsp_data_o), .busy_o(busy_o), .pins_o(pins_o), .dq_i(dq_i), .ready_busy_n_i(ready_busy_n_i));
  fab_flash_model #(.BUSY_CYC(6)) model_u (.clk_i(clk_i), .pins_i(pins_o), .dq_o(dq_i),
    .ready_busy_n_o(ready_busy_n_i));
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp)
    begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic send(input fab_pkg::fab_op_t op, input logic [20:0] a, input logic [15:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    req_valid_i <= 1'b1;
    req_i <= '{op: op, addr: a, wdata: d};
    @(negedge clk_i);
    while (req_ready_o !== 1'b1 && n < 60)
    begin
      @(negedge clk_i);
      n++;
    end
    chk("req_ready", 32'h1, {31'h0, req_ready_o});
    @(posedge clk_i);
    req_valid_i <= 1'b0;
  endtask
  task automatic rd(input fab_pkg::fab_op_t op, input logic [20:0] a, input logic [15:0] exp);
    int n;
    int low;
    n = 0;
    low = 0;
    send(op, a, 16'h0000);
    @(negedge clk_i);
    while (rsp_valid_o !== 1'b1 && n < 20)
    begin
      if (pins_o.oe_n === 1'b0)
        low++;
      @(negedge clk_i);
      n++;
    end
    chk("oe low long enough", 32'h1, {31'h0, low >= 2});
    chk("rsp_valid", 32'h1, {31'h0, rsp_valid_o});
    chk("rsp_data", {16'h0, exp}, {16'h0, rsp_data_o});
  endtask
  task automatic test_read;
    rd(fab_pkg::FAB_OP_READ, 21'h000000, 16'ha500);
    rd(fab_pkg::FAB_OP_READ, 21'h1fffff, 16'h5aff);
    $display("read test done");
  endtask
  task automatic test_width;
    @(posedge clk_i);
    word_mode_i <= 1'b0;
    rd(fab_pkg::FAB_OP_READ, 21'h000037, 16'h0037);
    chk("width_select", 32'h0, {31'h0, pins_o.width_select});
    @(posedge clk_i);
    word_mode_i <= 1'b1;
    rd(fab_pkg::FAB_OP_READ, 21'h000037, 16'h9237);
    $display("width test done");
  endtask
  task automatic test_write;
    int n;
    n = 0;
    send(fab_pkg::FAB_OP_WRITE, 21'h000555, 16'h00aa);
    @(negedge clk_i);
    chk("write we_n", 32'h0, {31'h0, pins_o.we_n});
    chk("write oe_n", 32'h1, {31'h0, pins_o.oe_n});
    chk("write data", 32'h00aa, {16'h0, pins_o.dq_o});
    chk("write addr", 32'h555, {11'h0, pins_o.addr});
    chk("write drive", 32'h1, {31'h0, pins_o.dq_oe});
    while (busy_o !== 1'b1 && n < 12)
    begin
      @(negedge clk_i);
      n++;
    end
    chk("busy seen", 32'h1, {31'h0, busy_o});
    chk("write released", 32'h0, {31'h0, pins_o.dq_oe});
    chk("refused while busy", 32'h0, {31'h0, req_ready_o});
    n = 0;
    while (busy_o !== 1'b0 && n < 30)
    begin
      @(negedge clk_i);
      n++;
    end
    chk("busy cleared", 32'h0, {31'h0, busy_o});
    rd(fab_pkg::FAB_OP_POLL, 21'h000555, 16'hf055);
    $display("write test done");
  endtask
  task automatic test_reset;
    int n;
    int low;
    n = 0;
    low = 0;
    send(fab_pkg::FAB_OP_RESET, 21'h0, 16'h0);
    while (n < 40 && !(low > 0 && pins_o.reset_n === 1'b1))
    begin
      @(negedge clk_i);
      if (pins_o.reset_n === 1'b0)
        low++;
      n++;
    end
    chk("reset low cycles", 32'd10, low);
    chk("select idle after reset", 32'h1, {31'h0, pins_o.sel_n});
    rd(fab_pkg::FAB_OP_READ, 21'h000012, 16'hb712);
    $display("reset test done");
  endtask
  task automatic stop_test;
    $display("comparisons %0d err_count %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // ceiling is well above the roughly 80 cycles the tests need
  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      err_count++;
      stop_test();
    end
  end
  initial
  begin
    repeat (6) @(posedge clk_i);
    rst_b_i <= 1'b1;
    test_read();
    test_width();
    test_write();
    test_reset();
    stop_test();
  end
endmodule
